// ===== src/async_channel_regs.svh
// Purpose: Constants for the asynchronous serial channel
// Assumes: One serial-clock tick is a one-cycle pulse on the system clock
// Notes:   Counts are in serial-clock ticks
`ifndef ASYNC_CHANNEL_REGS_SVH
`define ASYNC_CHANNEL_REGS_SVH

// -----------------------------------------------------------------------
// Sample timing
// -----------------------------------------------------------------------
`define HALF_BIT_TICKS   4'h7
`define FULL_BIT_TICKS   4'hf

// -----------------------------------------------------------------------
// Parity select encodings
// -----------------------------------------------------------------------
`define PAR_NONE         2'h0
`define PAR_ZERO         2'h1
`define PAR_ODD          2'h2
`define PAR_EVEN         2'h3

// -----------------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------------
`define RX_BUF_RESET     9'h000
`define TX_FRAME_RESET   12'hfff

`endif

// ===== src/async_channel_pkg.sv
// Purpose: Types for the asynchronous serial channel
// Assumes: Nothing beyond the header constants
// Notes:   Mode and status travel as packed structs
package async_channel_pkg;

  // ---------------------------------------------------------------------
  // Mode and status carriers
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic [1:0] parity_select;
    logic       char_length_sel;
    logic       two_stop_sel;
    logic       expansion_bit_sel;
  } async_mode_s;

  typedef struct packed {
    logic parity_err_flag;
    logic framing_err_flag;
    logic overrun_err_flag;
  } async_status_s;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } rx_state_e;

endpackage

// ===== src/async_rx_sync.sv
// Purpose: Three-stage pin synchroniser with agreement filter
// Assumes: Pin is asynchronous to the system clock
// Notes:   Output changes once stages two and three agree
module async_rx_sync (
  input  wire logic i_sys_clk,
  input  wire logic i_rst_n,
  input  wire logic i_pin,
  output logic      o_level
);

  logic [2:0] sync_q;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync_q <= 3'h7;
    end else begin
      sync_q <= {sync_q[1:0], i_pin};
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_level <= 1'b1;
    end else if (sync_q[1] == sync_q[2]) begin
      o_level <= sync_q[2];
    end
  end

endmodule

// ===== src/async_channel.sv
// Purpose: Full-duplex asynchronous serial channel with three requests
// Assumes: i_serial_tick pulses once per baud-generator serial clock
// Notes:   Request outputs are one-cycle pulses
`include "async_channel_regs.svh"

module async_channel (
  input  wire logic                          i_sys_clk,
  input  wire logic                          i_rst_n,
  input  wire logic                          i_serial_tick,
  input  wire async_channel_pkg::async_mode_s i_mode,
  input  wire logic                          i_async_tx_enable,
  input  wire logic                          i_async_rx_enable,
  input  wire logic                          i_tx_write,
  input  wire logic [8:0]                    i_tx_shift_word,
  input  wire logic                          i_rx_buffer_read,
  input  wire logic                          i_rx_pin,
  output logic                               o_tx_pin,
  output logic [8:0]                         o_rx_buffer_word,
  output async_channel_pkg::async_status_s   o_async_status,
  output logic                               o_tx_busy,
  output logic                               o_rx_error_irq,
  output logic                               o_rx_done_irq,
  output logic                               o_tx_done_irq
);

  import async_channel_pkg::*;

  // ---------------------------------------------------------------------
  // Frame format helpers
  // ---------------------------------------------------------------------
  function automatic logic [3:0] data_bits(input async_mode_s m);
    if (m.parity_select == `PAR_NONE && m.expansion_bit_sel) begin
      data_bits = 4'h9;
    end else if (m.char_length_sel) begin
      data_bits = 4'h8;
    end else begin
      data_bits = 4'h7;
    end
  endfunction

  function automatic logic par_bit(input async_mode_s m,
                                   input logic [8:0]  d);
    logic ones;
    ones = ^(m.char_length_sel ? d[7:0] : {1'b0, d[6:0]});
    case (m.parity_select)
      `PAR_ODD:  par_bit = ~ones;
      `PAR_EVEN: par_bit = ones;
      default:   par_bit = 1'b0;
    endcase
  endfunction

  function automatic logic has_par(input async_mode_s m);
    has_par = m.parity_select != `PAR_NONE;
  endfunction

  function automatic logic checks_par(input async_mode_s m);
    checks_par = m.parity_select == `PAR_ODD ||
                 m.parity_select == `PAR_EVEN;
  endfunction

  function automatic logic bit_due(input logic       tick,
                                   input logic [3:0] count);
    bit_due = tick && count == `FULL_BIT_TICKS;
  endfunction

  // ---------------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------------
  logic [1:0] rst_sync_q;
  logic       rst_n;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_q[1];

  // ---------------------------------------------------------------------
  // Transmitter
  // ---------------------------------------------------------------------
  logic [11:0] tx_frame_q;
  logic [3:0]  tx_bits_left_q;
  logic [3:0]  tx_tick_q;
  logic        tx_busy_q;
  logic        tx_take;
  logic        tx_bit_end;
  logic [11:0] tx_frame_d;
  logic [3:0]  tx_len_d;
  logic [3:0]  tx_dbits;
  logic        tx_has_par;

  // Writes only land when enabled and idle
  assign tx_take    = i_tx_write && i_async_tx_enable &&
                      !tx_busy_q;
  assign tx_bit_end = tx_busy_q && bit_due(i_serial_tick, tx_tick_q);
  assign tx_dbits   = data_bits(i_mode);
  assign tx_has_par = has_par(i_mode);

  // Build frame: start, data LSB first, parity, stop(s), rest idle high
  always_comb begin
    tx_frame_d = 12'hfff;
    tx_frame_d[0] = 1'b0;
    for (int i = 0; i < 9; i++) begin
      if (4'(i) < tx_dbits) begin
        tx_frame_d[i + 1] = i_tx_shift_word[i];
      end
    end
    if (tx_has_par) begin
      tx_frame_d[tx_dbits + 4'h1] = par_bit(i_mode, i_tx_shift_word);
    end
    // Total frame bits: start + data + parity + stops
    tx_len_d = 4'(tx_dbits + 4'h2 + {3'h0, tx_has_par} +
                  {3'h0, i_mode.two_stop_sel});
  end

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_busy_q <= 1'b0;
    end else if (tx_take) begin
      tx_busy_q <= 1'b1;
    end else if (tx_bit_end && tx_bits_left_q == 4'h1) begin
      tx_busy_q <= 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_frame_q <= `TX_FRAME_RESET;
    end else if (tx_take) begin
      tx_frame_q <= tx_frame_d;
    end else if (tx_bit_end) begin
      tx_frame_q <= {1'b1, tx_frame_q[11:1]};
    end
  end

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_bits_left_q <= 4'h0;
    end else if (tx_take) begin
      tx_bits_left_q <= tx_len_d;
    end else if (tx_bit_end) begin
      tx_bits_left_q <= tx_bits_left_q - 4'h1;
    end
  end

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_tick_q <= 4'h0;
    end else if (tx_take) begin
      tx_tick_q <= 4'h0;
    end else if (tx_busy_q && i_serial_tick) begin
      tx_tick_q <= tx_tick_q + 4'h1;
    end
  end

  // Pulse as the final bit begins; reset never raises it
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_tx_done_irq <= 1'b0;
    end else begin
      o_tx_done_irq <= tx_bit_end && tx_bits_left_q == 4'h2;
    end
  end

  assign o_tx_pin  = tx_frame_q[0];
  assign o_tx_busy = tx_busy_q;

  // ---------------------------------------------------------------------
  // Receive pin synchroniser
  // ---------------------------------------------------------------------
  logic rx_level;

  async_rx_sync u_rx_sync (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (rst_n),
    .i_pin     (i_rx_pin),
    .o_level   (rx_level)
  );

  // ---------------------------------------------------------------------
  // Receiver
  // ---------------------------------------------------------------------
  rx_state_e   rx_state_q;
  logic [3:0]  rx_tick_q;
  logic [3:0]  rx_bits_left_q;
  logic [8:0]  rx_shift_q;
  logic        rx_par_q;
  logic [3:0]  rx_dbits;
  logic        rx_has_par;
  logic        rx_sample;
  logic        rx_frame_end;
  logic        rx_par_err;
  logic        rx_overrun;
  logic        rx_unread_q;

  assign rx_dbits   = data_bits(i_mode);
  assign rx_has_par = has_par(i_mode);
  assign rx_sample  = bit_due(i_serial_tick, rx_tick_q);
  assign rx_frame_end = rx_state_q == RX_STOP && rx_sample &&
                        i_async_rx_enable;

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_state_q     <= RX_IDLE;
      rx_tick_q      <= 4'h0;
      rx_bits_left_q <= 4'h0;
      rx_shift_q     <= 9'h000;
      rx_par_q       <= 1'b0;
    end else if (!i_async_rx_enable) begin
      rx_state_q <= RX_IDLE;
      rx_tick_q  <= 4'h0;
    end else if (i_serial_tick) begin
      case (rx_state_q)
        RX_IDLE: begin
          rx_tick_q <= 4'h0;
          if (!rx_level) begin
            rx_state_q <= RX_START;
          end
        end
        RX_START: begin
          if (rx_tick_q == `HALF_BIT_TICKS) begin
            rx_tick_q <= 4'h0;
            if (rx_level) begin
              rx_state_q <= RX_IDLE;
            end else begin
              rx_state_q     <= RX_DATA;
              rx_bits_left_q <= 4'(rx_dbits + {3'h0, rx_has_par});
              rx_shift_q     <= 9'h000;
            end
          end else begin
            rx_tick_q <= rx_tick_q + 4'h1;
          end
        end
        RX_DATA: begin
          rx_tick_q <= rx_tick_q + 4'h1;
          if (rx_tick_q == `FULL_BIT_TICKS) begin
            rx_bits_left_q <= rx_bits_left_q - 4'h1;
            if (rx_has_par && rx_bits_left_q == 4'h1) begin
              rx_par_q <= rx_level;
            end else begin
              rx_shift_q[4'(rx_dbits - rx_bits_left_q + {3'h0, rx_has_par})]
                <= rx_level;
            end
            if (rx_bits_left_q == 4'h1) begin
              rx_state_q <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          rx_tick_q <= rx_tick_q + 4'h1;
          if (rx_tick_q == `FULL_BIT_TICKS) begin
            rx_state_q <= RX_IDLE;
          end
        end
        default: begin
          rx_state_q <= RX_IDLE;
        end
      endcase
    end
  end

  // Zero parity never flags; none has no parity bit
  assign rx_par_err = checks_par(i_mode) &&
                      rx_par_q != par_bit(i_mode, rx_shift_q);
  assign rx_overrun = rx_unread_q;

  // ---------------------------------------------------------------------
  // Receive buffer and status
  // ---------------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_rx_buffer_word <= `RX_BUF_RESET;
    end else if (rx_frame_end) begin
      o_rx_buffer_word <= rx_shift_q;
    end
  end

  // New frame wins over a same-cycle read
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_unread_q <= 1'b0;
    end else if (rx_frame_end) begin
      rx_unread_q <= 1'b1;
    end else if (i_rx_buffer_read) begin
      rx_unread_q <= 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_async_status <= '0;
    end else if (rx_frame_end) begin
      o_async_status.parity_err_flag  <= rx_par_err;
      o_async_status.framing_err_flag <= !rx_level;
      o_async_status.overrun_err_flag <= rx_overrun;
    end else if (i_rx_buffer_read) begin
      o_async_status <= '0;
    end
  end

  // ---------------------------------------------------------------------
  // Receive requests
  // ---------------------------------------------------------------------
  // Error and done pulse together; error has priority 1, done 2, tx 3
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_rx_done_irq <= 1'b0;
    end else begin
      o_rx_done_irq <= rx_frame_end;
    end
  end

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_rx_error_irq <= 1'b0;
    end else begin
      o_rx_error_irq <= rx_frame_end &&
                        (rx_par_err || !rx_level || rx_overrun);
    end
  end

endmodule

// ===== dv/async_channel_monitor.sv
// Purpose: Port-level checks for the asynchronous serial channel
// Assumes: Writes come no earlier than the third edge after reset release
// Notes:   Bound to every instance of the channel
module async_channel_monitor (
  input wire logic                             i_sys_clk,
  input wire logic                             i_rst_n,
  input wire logic                             i_async_tx_enable,
  input wire logic                             i_async_rx_enable,
  input wire logic                             i_tx_write,
  input wire logic                             i_rx_buffer_read,
  input wire logic                             o_tx_pin,
  input wire logic [8:0]                       o_rx_buffer_word,
  input wire async_channel_pkg::async_status_s o_async_status,
  input wire logic                             o_tx_busy,
  input wire logic                             o_rx_error_irq,
  input wire logic                             o_rx_done_irq,
  input wire logic                             o_tx_done_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  import async_channel_pkg::*;
  // -------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  a_tx_start_bit: assert property (
    i_tx_write && i_async_tx_enable && !o_tx_busy |=> o_tx_busy && !o_tx_pin)
    else $error("accepted write did not start a frame");
  a_tx_write_dropped: assert property (
    i_tx_write && !i_async_tx_enable && !o_tx_busy |=> !o_tx_busy)
    else $error("write with transmit disabled started a frame");
  a_start_bit_low: assert property (
    $rose(o_tx_busy) |-> (!o_tx_pin) [*8])
    else $error("start bit not held low");
  a_tx_done_last: assert property (
    o_tx_done_irq |-> o_tx_busy && o_tx_pin ##1 !o_tx_done_irq)
    else $error("transmit done not at start of stop bit");
  a_tx_idle_high: assert property (
    !o_tx_busy |-> o_tx_pin)
    else $error("line not idle high while not busy");
  a_err_with_done: assert property (
    o_rx_error_irq |-> o_rx_done_irq)
    else $error("error request without receive done");
  a_err_is_or: assert property (
    o_rx_done_irq |-> o_rx_error_irq == (|o_async_status))
    else $error("error request differs from OR of flags");
  a_rx_off_quiet: assert property (
    (!i_async_rx_enable) [*3] |-> !o_rx_done_irq && !o_rx_error_irq)
    else $error("receive request while disabled");
  a_rx_buf_kept: assert property (
    (!i_async_rx_enable) [*3] |-> $stable(o_rx_buffer_word))
    else $error("buffer changed while disabled");
  a_read_clears: assert property (
    i_rx_buffer_read |=> o_async_status == 3'h0 || o_rx_done_irq)
    else $error("buffer read did not clear flags");

  c_tx_done: cover property (o_tx_done_irq);
  c_rx_err: cover property (o_rx_error_irq && o_rx_done_irq);
  c_rx_ok: cover property (o_rx_done_irq && !o_rx_error_irq);
endmodule

bind async_channel async_channel_monitor i_async_channel_monitor (
  .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
  .i_async_tx_enable(i_async_tx_enable),
  .i_async_rx_enable(i_async_rx_enable),
  .i_tx_write(i_tx_write), .i_rx_buffer_read(i_rx_buffer_read),
  .o_tx_pin(o_tx_pin), .o_rx_buffer_word(o_rx_buffer_word),
  .o_async_status(o_async_status), .o_tx_busy(o_tx_busy),
  .o_rx_error_irq(o_rx_error_irq), .o_rx_done_irq(o_rx_done_irq),
  .o_tx_done_irq(o_tx_done_irq));

// ===== dv/async_far_end.sv
// Purpose: Remote transceiver on the serial lines
// Assumes: Shares the serial tick; 16 ticks per bit
// Notes:   Line idles high, as with a pull-up
module async_far_end (
  input  wire logic i_sys_clk,
  input  wire logic i_serial_tick,
  input  wire logic i_line,
  output logic      o_line
);
  timeunit 1ns;
  timeprecision 1ps;
  initial o_line = 1'b1;
  // -------------------------------------------------------------------
  // Line tasks
  // -------------------------------------------------------------------
  task automatic ticks(input int n);
    repeat (n) @(posedge i_sys_clk iff i_serial_tick);
  endtask
  // Start, data LSB first, parity, stops
  task automatic send(input logic [12:0] f, input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge i_sys_clk) o_line = f[i];
      ticks(16);
    end
    @(negedge i_sys_clk) o_line = 1'b1;
  endtask
  task automatic glitch(input int n);
    @(negedge i_sys_clk) o_line = 1'b0;
    ticks(n);
    @(negedge i_sys_clk) o_line = 1'b1;
  endtask
  // Samples each bit near its middle
  task automatic grab(input int n, output logic [12:0] g);
    g = '1;
    @(negedge i_line);
    ticks(8);
    for (int i = 0; i < n; i++) begin
      g[i] = i_line;
      ticks(16);
    end
  endtask
endmodule

// ===== dv/async_channel_test.sv
// Purpose: Self-checking bench for the asynchronous serial channel
// Assumes: Serial tick every second system cycle
// Notes:   Transmit and receive run at once in the mode sweep
module async_channel_test;
  timeunit 1ns;
  timeprecision 1ps;
  import async_channel_pkg::*;
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
  num_errors++; $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
  logic clk, rst_n, tick, txe, rxe, txw, rd, rxp, txp, busy, erq, drq, tdq;
  logic [8:0] txd, rbuf;
  async_mode_s mode;
  async_status_s st;
  int num_errors, tests_run, tdone, rdone, rerr;

  async_channel i_async_channel (.i_sys_clk(clk), .i_rst_n(rst_n),
    .i_serial_tick(tick), .i_mode(mode), .i_async_tx_enable(txe),
    .i_async_rx_enable(rxe), .i_tx_write(txw), .i_tx_shift_word(txd),
    .i_rx_buffer_read(rd), .i_rx_pin(rxp), .o_tx_pin(txp),
    .o_rx_buffer_word(rbuf), .o_async_status(st), .o_tx_busy(busy),
    .o_rx_error_irq(erq), .o_rx_done_irq(drq), .o_tx_done_irq(tdq));
  async_far_end i_async_far_end (.i_sys_clk(clk), .i_serial_tick(tick),
    .i_line(txp), .o_line(rxp));

  // -------------------------------------------------------------------
  // Clock, tick, event counts
  // -------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(negedge clk) tick <= ~tick;
  always @(negedge clk) begin
    if (tdq === 1'b1) tdone++;
    if (drq === 1'b1) rdone++;
    if (erq === 1'b1) rerr++;
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr(input logic [8:0] w);
    @(negedge clk) begin txw = 1'b1; txd = w; end
    @(negedge clk) txw = 1'b0;
  endtask
  task automatic rdbuf;
    @(negedge clk) rd = 1'b1;
    @(negedge clk) rd = 1'b0;
  endtask
  task automatic results;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Reference frame and stored word for a mode
  function automatic void mk(input logic [8:0] w, input async_mode_s m,
      output logic [12:0] f, output int n, output logic [8:0] d);
    int nd;
    nd = (m.parity_select == 2'h0 && m.expansion_bit_sel) ? 9 :
         (m.char_length_sel ? 8 : 7);
    d = w & ((9'h1 << nd) - 9'h1);
    f = '1;
    f[0] = 1'b0;
    for (int i = 0; i < nd; i++) f[i+1] = d[i];
    n = nd + 1;
    if (m.parity_select != 2'h0) begin
      f[n] = (m.parity_select == 2'h1) ? 1'b0 :
             (m.parity_select == 2'h3) ? ^d : ~^d;
      n++;
    end
    n = n + (m.two_stop_sel ? 2 : 1);
  endfunction

  initial begin
    #400us;
    num_errors++;
    results;
  end

  // -------------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------------
  initial begin
    logic [8:0] w, v, dt, dr, b;
    logic [12:0] ft, fr, g;
    int nt, nr, d0, te, e0;
    void'($urandom(32'hc35c));
    rst_n = 1'b0; tick = 1'b0; txe = 1'b1; rxe = 1'b1; txw = 1'b0;
    rd = 1'b0; txd = '0; mode = '0; te = 0;
    cyc(2);
    rst_n = 1'b1;
    cyc(3);
    `CHK("tx_done_reset", 0, tdone)
    for (int m = 0; m < 32; m++) begin
      @(negedge clk) mode = m[4:0];
      w = 9'($urandom);
      v = 9'($urandom);
      mk(w, mode, ft, nt, dt);
      mk(v, mode, fr, nr, dr);
      d0 = rdone;
      fork
        i_async_far_end.grab(nt, g);
        begin wr(w); cyc(100); wr(~w); end
        i_async_far_end.send(fr, nr);
      join
      cyc(40);
      te++;
      `CHK("tx_frame", ft, g)
      `CHK("tx_done", te, tdone)
      `CHK("rx_word", dr, rbuf)
      `CHK("rx_done", d0 + 1, rdone)
      `CHK("status", 3'h0, st)
      rdbuf;
    end
    txe = 1'b0;
    wr(9'h055);
    cyc(4);
    `CHK("tx_busy_off", 1'b0, busy)
    txe = 1'b1;
    mode = 5'h14;
    v = 9'($urandom);
    mk(v, mode, fr, nr, dr);
    fr[9] = ~fr[9];
    e0 = rerr;
    i_async_far_end.send(fr, nr);
    cyc(40);
    `CHK("par_err", 3'h4, st)
    `CHK("err_irq", e0 + 1, rerr)
    `CHK("err_word", dr, rbuf)
    mk(~v, mode, fr, nr, dr);
    fr[10] = 1'b0;
    i_async_far_end.send(fr, nr);
    cyc(40);
    `CHK("frm_ovr", 3'h3, st)
    `CHK("ovr_word", dr, rbuf)
    cyc(600);
    rdbuf;
    cyc(2);
    `CHK("read_clr", 3'h0, st)
    d0 = rdone;
    i_async_far_end.glitch(4);
    cyc(200);
    `CHK("false_start", d0, rdone)
    v = 9'($urandom);
    mk(v, mode, fr, nr, dr);
    i_async_far_end.send(fr, nr);
    cyc(40);
    `CHK("after_false", dr, rbuf)
    rdbuf;
    b = rbuf;
    d0 = rdone;
    mk(~v, mode, fr, nr, dr);
    fork
      i_async_far_end.send(fr, nr);
      begin i_async_far_end.ticks(60); @(negedge clk) rxe = 1'b0; end
    join
    cyc(40);
    `CHK("abort_done", d0, rdone)
    `CHK("abort_buf", b, rbuf)
    rxe = 1'b1;
    wr(9'h0a5);
    cyc(100);
    rst_n = 1'b0;
    cyc(2);
    rst_n = 1'b1;
    cyc(4);
    `CHK("reset_tx_done", te, tdone)
    `CHK("reset_idle", 1'b1, txp)
    results;
  end
endmodule
